// File: cam_pkg.sv
// shared constants and carrier types for the controller address map
package cam_pkg;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 8;
	localparam int NUM_OBJ  = 15;
	localparam int OBJ_W    = 4;
	// fixed register locations in the byte map
	localparam logic [7:0] A_MAIN_CTRL  = 8'h00;
	localparam logic [7:0] A_MAIN_STAT  = 8'h01;
	localparam logic [7:0] A_HOST_CFG   = 8'h02;
	localparam logic [7:0] A_RSVD_03    = 8'h03;
	localparam logic [7:0] A_FAST_LO    = 8'h04;
	localparam logic [7:0] A_FAST_HI    = 8'h05;
	localparam logic [7:0] A_GM_SHORT   = 8'h06;
	localparam logic [7:0] A_GM_LONG    = 8'h08;
	localparam logic [7:0] A_LAST_MASK  = 8'h0C;
	localparam logic [7:0] A_CLK_OUT    = 8'h1F;
	localparam logic [7:0] A_BUS_CFG    = 8'h2F;
	localparam logic [7:0] A_BIT_T0     = 8'h3F;
	localparam logic [7:0] A_BIT_T1     = 8'h4F;
	localparam logic [7:0] A_INT_SRC    = 8'h5F;
	localparam logic [7:0] A_PA_DIR     = 8'h9F;
	localparam logic [7:0] A_PB_DIR     = 8'hAF;
	localparam logic [7:0] A_PA_LVL     = 8'hBF;
	localparam logic [7:0] A_PB_LVL     = 8'hCF;
	localparam logic [7:0] A_PA_OUT     = 8'hDF;
	localparam logic [7:0] A_PB_OUT     = 8'hEF;
	localparam logic [7:0] A_RESYNC     = 8'hFF;
	// object layout: low nibble is the byte inside the object
	localparam logic [3:0] OBJ_REG_IDX  = 4'hF;
	localparam logic [3:0] IDX_CTL1     = 4'h1;
	localparam logic [3:0] IDX_FCFG     = 4'h6;
	localparam logic [3:0] LAST_OBJ     = 4'hF;
	localparam logic [3:0] SHADOW_SLOT  = 4'h0;
	// field positions
	localparam int CTL1_TX_BIT  = 0;
	localparam int CTL1_RX_BIT  = 1;
	localparam int FCFG_DIR_BIT = 3;
	localparam int CTRL_IE_BIT  = 1;
	localparam int STAT_TX_BIT  = 3;
	localparam int STAT_RX_BIT  = 4;
	localparam int CFG_INTB_BIT = 5;
	localparam int BUS_BYP_BIT  = 6;
	localparam int BUS_TXB_BIT  = 3;
	localparam int CLK_SLEW_LO  = 4;
	localparam int PB_INT_BIT   = 6;
	localparam int PB_WRH_BIT   = 7;
	// reset and fixed read values
	localparam logic [7:0] CTRL_RST     = 8'h01;
	localparam logic [7:0] REG_RST      = 8'h00;
	localparam logic [7:0] RSVD_VAL     = 8'h00;
	localparam logic [7:0] RESYNC_VAL   = 8'hFF;
	localparam logic [7:0] INT_BASE     = 8'h02;
	localparam logic [3:0] DIV_MAX      = 4'hE;

	typedef enum logic [2:0] {
		CAM_MUX8_A  = 3'b000,
		CAM_MUX16   = 3'b001,
		CAM_MUX8_B  = 3'b011,
		CAM_SPLIT8  = 3'b010,
		CAM_SERIAL  = 3'b110
	} cam_mode_e;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cam_host_req_s;

	typedef struct packed {
		logic       wr;
		logic [3:0] obj;
		logic [3:0] idx;
		logic [7:0] wdata;
	} cam_eng_req_s;

	typedef struct packed {
		logic [15:0] short_id;
		logic [31:0] long_id;
		logic [31:0] last_obj;
	} cam_mask_s;
endpackage

// File: cam_msg_ram.sv
// true dual-port message storage, registered read data on both ports
`timescale 1ns/1ps
module cam_msg_ram import cam_pkg::*; #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic          core_clk,
	input  wire logic          a_we,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [DW-1:0] a_wdata,
	output logic      [DW-1:0] a_rdata,
	input  wire logic          b_we,
	input  wire logic [AW-1:0] b_addr,
	input  wire logic [DW-1:0] b_wdata,
	output logic      [DW-1:0] b_rdata
);
	logic [DW-1:0] mem [2**AW];

	// port a is written last so the host wins a same-address collision
	always_ff @(posedge core_clk) begin
		if (b_we) begin
			mem[b_addr] <= b_wdata;
		end
		if (a_we) begin
			mem[a_addr] <= a_wdata;
		end
	end

	// both ports read every cycle, neither waits for the other
	always_ff @(posedge core_clk) begin
		a_rdata <= mem[a_addr];
		b_rdata <= mem[b_addr];
	end
endmodule

// File: cam_clk_div.sv
// programmable divider for the clock output pin
`timescale 1ns/1ps
module cam_clk_div import cam_pkg::*; (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] div_sel,
	output logic            clk_out
);
	logic [3:0] cnt_r;
	logic [3:0] ratio;

	// a setting above fourteen is held at the deepest ratio of fourteen, a fifteen-cycle period
	assign ratio = (div_sel > DIV_MAX) ? DIV_MAX : div_sel;

	// period is ratio+1 cycles; high from the last count through the first half, ratio one stays high
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 4'h0;
		end else if (cnt_r >= ratio) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_out <= 1'b0;
		end else begin
			clk_out <= (cnt_r >= ratio) || ({cnt_r, 1'b0} < ratio);
		end
	end
endmodule

// File: cam_map_top.sv
// address map, message storage, ports and clock output of the controller
`timescale 1ns/1ps
// Functional notes
// - fifteen message objects, each with up to eight data bytes
// - message storage is dual ported; host and engine never block
// - two select pins plus serial strap choose the host interface
// - parallel: two 8-bit muxed styles, 16-bit muxed, 8-bit split
// - serial mode is slave only, the master drives every transfer
// - two 8-bit general ports, each bit input or output
// - second port bits five to zero are always general pins
// - second port bit six may carry interrupt, bit seven high strobe
// - first port is general only in variants 0, 2 and serial
// - clock output divides the core clock by one to fifteen
// - clock output register at 1FH selects the pin slew rate
// - 256 byte locations hold registers and object storage
// - object bytes: two control, four identifier, config, eight data
// - last object is receive only, double buffered, own mask
// - other objects have an identifier and transmit or receive role
// - each object keeps separate transmit and receive status flags
// - global mask: short form at 06-07H, long form at 08-0BH
// - engine moves data through two receive and two transmit lines
// - address FFH is the serial resync location, not storage
module cam_map_top import cam_pkg::*; (
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	input  wire logic          host_select_low,
	input  wire logic          host_select_high,
	input  wire logic          host_serial_strap,
	input  wire cam_host_req_s host_req,
	output logic      [7:0]    host_rdata,
	output logic               host_rvalid,
	output cam_mode_e          host_mode,
	input  wire cam_eng_req_s  eng_req,
	output logic      [7:0]    eng_rdata,
	input  wire logic          eng_tx_done,
	input  wire logic          eng_rx_done,
	input  wire logic [3:0]    eng_evt_obj,
	input  wire logic          eng_tx_bit,
	output logic               eng_rx_bit,
	output logic [NUM_OBJ:1]   obj_is_tx,
	output cam_mask_s          eng_masks,
	output logic [7:0]         eng_bus_cfg,
	output logic [15:0]        eng_bit_time,
	input  wire logic          bus_receive_a,
	input  wire logic          bus_receive_b,
	output logic               bus_transmit_a,
	output logic               bus_transmit_b,
	input  wire logic [7:0]    port_a_in,
	output logic      [7:0]    port_a_out,
	output logic      [7:0]    port_a_oe,
	input  wire logic [7:0]    port_b_in,
	output logic      [7:0]    port_b_out,
	output logic      [7:0]    port_b_oe,
	output logic               int_b,
	output logic               clk_out,
	output logic      [1:0]    clk_out_slew
);
	logic [7:0]  ctrl_r, stat_r, cfg_r, clk_div_r, bus_cfg_r;
	logic [7:0]  bt0_r, bt1_r, pa_dir_r, pb_dir_r, pa_out_r, pb_out_r;
	logic [15:0] gm_short_r, fast_r;
	logic [31:0] gm_long_r, last_mask_r;
	logic [NUM_OBJ:1] tx_flag_r, rx_flag_r, dir_r;
	logic        bank_r, mode_taken_r, ram_sel_r, rd_pend_r;
	logic [7:0]  reg_rdata_r, ctl1_ovl_r, ram_a_rdata;
	logic [7:0]  int_src, ram_a_addr, ram_b_addr;
	logic [3:0]  h_obj, h_idx;
	logic        h_is_obj, h_wr, tx_evt, rx_evt;
	cam_mode_e   mode_r;

	// true when a byte address falls in object storage, false for a register location
	function automatic logic is_obj(input logic [7:0] a);
		return (a[7:4] != 4'h0) && (a[3:0] != OBJ_REG_IDX);
	endfunction

	// storage slot of an object; the last object flips between two slots
	function automatic logic [3:0] slot(input logic [3:0] obj,
	                                   input logic       alt);
		if (obj != LAST_OBJ) begin
			return obj;
		end
		return alt ? SHADOW_SLOT : LAST_OBJ;
	endfunction

	// true when an object number names one of the fifteen objects
	function automatic logic obj_ok(input logic [3:0] obj);
		return obj != 4'h0;
	endfunction

	assign h_obj    = host_req.addr[7:4];
	assign h_idx    = host_req.addr[3:0];
	assign h_is_obj = is_obj(host_req.addr);
	assign h_wr     = host_req.wr && !host_req.rd;

	// strap pins are caught once in the first clock after reset release
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_taken_r <= 1'b0;
			mode_r       <= CAM_MUX8_A;
		end else if (!mode_taken_r) begin
			mode_taken_r <= 1'b1;
			unique case ({host_serial_strap, host_select_high,
			              host_select_low})
				3'b000:  mode_r <= CAM_MUX8_A;
				3'b001:  mode_r <= CAM_MUX16;
				3'b010:  mode_r <= CAM_MUX8_B;
				3'b011:  mode_r <= CAM_SPLIT8;
				default: mode_r <= CAM_SERIAL;
			endcase
		end
	end
	// the serial front end only answers; clock and select come from outside
	assign host_mode = mode_r;

	// dual-port storage: host on port a, engine on port b
	assign ram_a_addr = {slot(h_obj, bank_r), h_idx};
	assign ram_b_addr = {slot(eng_req.obj, !bank_r), eng_req.idx};

	cam_msg_ram #(
		.AW (ADDR_W),
		.DW (DATA_W)
	) u_ram (
		.core_clk (core_clk),
		.a_we     (h_wr && h_is_obj),
		.a_addr   (ram_a_addr),
		.a_wdata  (host_req.wdata),
		.a_rdata  (ram_a_rdata),
		.b_we     (eng_req.wr && obj_ok(eng_req.obj)),
		.b_addr   (ram_b_addr),
		.b_wdata  (eng_req.wdata),
		.b_rdata  (eng_rdata)
	);

	// configuration registers written by the host
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r      <= CTRL_RST;
			cfg_r       <= REG_RST;
			clk_div_r   <= REG_RST;
			bus_cfg_r   <= REG_RST;
			bt0_r       <= REG_RST;
			bt1_r       <= REG_RST;
			gm_short_r  <= {2{REG_RST}};
			gm_long_r   <= {4{REG_RST}};
			last_mask_r <= {4{REG_RST}};
		end else if (h_wr && !h_is_obj) begin
			unique case (host_req.addr)
				A_MAIN_CTRL:     ctrl_r <= host_req.wdata;
				A_HOST_CFG:      cfg_r  <= host_req.wdata;
				A_CLK_OUT:       clk_div_r <= host_req.wdata;
				A_BUS_CFG:       bus_cfg_r <= host_req.wdata;
				A_BIT_T0:        bt0_r  <= host_req.wdata;
				A_BIT_T1:        bt1_r  <= host_req.wdata;
				A_GM_SHORT:      gm_short_r[7:0]  <= host_req.wdata;
				A_GM_SHORT+8'h1: gm_short_r[15:8] <= host_req.wdata;
				A_GM_LONG:       gm_long_r[7:0]   <= host_req.wdata;
				A_GM_LONG+8'h1:  gm_long_r[15:8]  <= host_req.wdata;
				A_GM_LONG+8'h2:  gm_long_r[23:16] <= host_req.wdata;
				A_GM_LONG+8'h3:  gm_long_r[31:24] <= host_req.wdata;
				A_LAST_MASK:       last_mask_r[7:0]   <= host_req.wdata;
				A_LAST_MASK+8'h1:  last_mask_r[15:8]  <= host_req.wdata;
				A_LAST_MASK+8'h2:  last_mask_r[23:16] <= host_req.wdata;
				A_LAST_MASK+8'h3:  last_mask_r[31:24] <= host_req.wdata;
				default: ; // reserved, read-only and FFH writes drop
			endcase
		end
	end

	// port registers live apart so the pin logic reads them in one place
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pa_dir_r <= REG_RST;
			pb_dir_r <= REG_RST;
			pa_out_r <= REG_RST;
			pb_out_r <= REG_RST;
		end else if (h_wr && !h_is_obj) begin
			unique case (host_req.addr)
				A_PA_DIR: pa_dir_r <= host_req.wdata;
				A_PB_DIR: pb_dir_r <= host_req.wdata;
				A_PA_OUT: pa_out_r <= host_req.wdata;
				A_PB_OUT: pb_out_r <= host_req.wdata;
				default: ;
			endcase
		end
	end

	// engine events that count: transmit only on transmit objects
	assign tx_evt = eng_tx_done && obj_ok(eng_evt_obj)
	                && dir_r[eng_evt_obj];
	assign rx_evt = eng_rx_done && obj_ok(eng_evt_obj)
	                && !dir_r[eng_evt_obj];

	// object role follows the direction bit of its config byte; the last object stays receive
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dir_r <= '0;
		end else if (h_wr && h_is_obj && h_idx == IDX_FCFG &&
		             h_obj != LAST_OBJ) begin
			dir_r[h_obj] <= host_req.wdata[FCFG_DIR_BIT];
		end
	end
	assign obj_is_tx = dir_r;

	// per-object flags; an event in the clearing cycle keeps the flag set
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_flag_r <= '0;
			rx_flag_r <= '0;
		end else begin
			for (int n = 1; n <= NUM_OBJ; n++) begin
				if (tx_evt && eng_evt_obj == n[3:0]) begin
					tx_flag_r[n] <= 1'b1;
				end else if (h_wr && h_is_obj && h_obj == n[3:0] &&
				             h_idx == IDX_CTL1 &&
				             !host_req.wdata[CTL1_TX_BIT]) begin
					tx_flag_r[n] <= 1'b0;
				end
				if (rx_evt && eng_evt_obj == n[3:0]) begin
					rx_flag_r[n] <= 1'b1;
				end else if (h_wr && h_is_obj && h_obj == n[3:0] &&
				             h_idx == IDX_CTL1 &&
				             !host_req.wdata[CTL1_RX_BIT]) begin
					rx_flag_r[n] <= 1'b0;
				end
			end
		end
	end

	// a finished receive into the last object swaps the two buffers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bank_r <= 1'b0;
		end else if (rx_evt && eng_evt_obj == LAST_OBJ) begin
			bank_r <= !bank_r;
		end
	end

	// summary status; set wins over the host's clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_r <= REG_RST;
		end else begin
			if (tx_evt) begin
				stat_r[STAT_TX_BIT] <= 1'b1;
			end else if (h_wr && host_req.addr == A_MAIN_STAT &&
			             !host_req.wdata[STAT_TX_BIT]) begin
				stat_r[STAT_TX_BIT] <= 1'b0;
			end
			if (rx_evt) begin
				stat_r[STAT_RX_BIT] <= 1'b1;
			end else if (h_wr && host_req.addr == A_MAIN_STAT &&
			             !host_req.wdata[STAT_RX_BIT]) begin
				stat_r[STAT_RX_BIT] <= 1'b0;
			end
		end
	end

	// interrupt code: lowest object with a pending flag, plus a base
	always_comb begin
		int_src = RSVD_VAL;
		for (int n = NUM_OBJ; n >= 1; n--) begin
			if (tx_flag_r[n] || rx_flag_r[n]) begin
				int_src = INT_BASE + 8'(n);
			end
		end
	end
	assign int_b = !(ctrl_r[CTRL_IE_BIT] && int_src != RSVD_VAL);

	// register read path, one cycle like the storage read
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_r <= RSVD_VAL;
		end else if (host_req.rd) begin
			unique case (host_req.addr)
				A_MAIN_CTRL:       reg_rdata_r <= ctrl_r;
				A_MAIN_STAT:       reg_rdata_r <= stat_r;
				A_HOST_CFG:        reg_rdata_r <= cfg_r;
				A_FAST_LO:         reg_rdata_r <= fast_r[7:0];
				A_FAST_HI:         reg_rdata_r <= fast_r[15:8];
				A_GM_SHORT:        reg_rdata_r <= gm_short_r[7:0];
				A_GM_SHORT+8'h1:   reg_rdata_r <= gm_short_r[15:8];
				A_GM_LONG:         reg_rdata_r <= gm_long_r[7:0];
				A_GM_LONG+8'h1:    reg_rdata_r <= gm_long_r[15:8];
				A_GM_LONG+8'h2:    reg_rdata_r <= gm_long_r[23:16];
				A_GM_LONG+8'h3:    reg_rdata_r <= gm_long_r[31:24];
				A_LAST_MASK:       reg_rdata_r <= last_mask_r[7:0];
				A_LAST_MASK+8'h1:  reg_rdata_r <= last_mask_r[15:8];
				A_LAST_MASK+8'h2:  reg_rdata_r <= last_mask_r[23:16];
				A_LAST_MASK+8'h3:  reg_rdata_r <= last_mask_r[31:24];
				A_CLK_OUT:         reg_rdata_r <= clk_div_r;
				A_BUS_CFG:         reg_rdata_r <= bus_cfg_r;
				A_BIT_T0:          reg_rdata_r <= bt0_r;
				A_BIT_T1:          reg_rdata_r <= bt1_r;
				A_INT_SRC:         reg_rdata_r <= int_src;
				A_PA_DIR:          reg_rdata_r <= pa_dir_r;
				A_PB_DIR:          reg_rdata_r <= pb_dir_r;
				A_PA_LVL:          reg_rdata_r <= port_a_in;
				A_PB_LVL:          reg_rdata_r <= port_b_in;
				A_PA_OUT:          reg_rdata_r <= pa_out_r;
				A_PB_OUT:          reg_rdata_r <= pb_out_r;
				A_RESYNC:          reg_rdata_r <= RESYNC_VAL;
				default:           reg_rdata_r <= RSVD_VAL;
			endcase
		end
	end

	// remember which source answers and the flag overlay for control 1
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_pend_r  <= 1'b0;
			ram_sel_r  <= 1'b0;
			ctl1_ovl_r <= REG_RST;
		end else begin
			rd_pend_r  <= host_req.rd;
			ram_sel_r  <= h_is_obj;
			ctl1_ovl_r <= REG_RST;
			if (host_req.rd && h_is_obj && h_idx == IDX_CTL1) begin
				ctl1_ovl_r[CTL1_TX_BIT] <= tx_flag_r[h_obj];
				ctl1_ovl_r[CTL1_RX_BIT] <= rx_flag_r[h_obj];
			end
		end
	end

	// storage bytes come from the ram output register, control 1 with the flags ORed in
	assign host_rdata  = ram_sel_r ? (ram_a_rdata | ctl1_ovl_r) : reg_rdata_r;
	assign host_rvalid = rd_pend_r;

	// fast read pair keeps the last two storage bytes the host read
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fast_r <= {2{REG_RST}};
		end else if (rd_pend_r && ram_sel_r) begin
			fast_r <= {fast_r[7:0], ram_a_rdata};
		end
	end

	// line interface: receive comparator or bypass, both transmit lines
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			eng_rx_bit     <= 1'b1;
			bus_transmit_a <= 1'b1;
			bus_transmit_b <= 1'b0;
		end else begin
			eng_rx_bit <= bus_cfg_r[BUS_BYP_BIT] ? bus_receive_a
			              : (bus_receive_a | !bus_receive_b);
			bus_transmit_a <= eng_tx_bit;
			bus_transmit_b <= bus_cfg_r[BUS_TXB_BIT] ? eng_tx_bit
			                  : !eng_tx_bit;
		end
	end

	assign eng_masks.short_id = gm_short_r;
	assign eng_masks.long_id  = gm_long_r;
	assign eng_masks.last_obj = last_mask_r;
	assign eng_bus_cfg        = bus_cfg_r;
	assign eng_bit_time       = {bt1_r, bt0_r};

	// first port gives way to the host bus in the 16-bit and split modes
	always_comb begin
		port_a_out = pa_out_r;
		port_a_oe  = pa_dir_r;
		if (mode_r == CAM_MUX16 || mode_r == CAM_SPLIT8) begin
			port_a_oe = '0;
		end
	end

	// second port: low six bits always general, six and seven may be taken
	always_comb begin
		port_b_out = pb_out_r;
		port_b_oe  = pb_dir_r;
		if (cfg_r[CFG_INTB_BIT]) begin
			port_b_out[PB_INT_BIT] = 1'b0; // open drain, drives only low
			port_b_oe[PB_INT_BIT]  = !int_b;
		end
		if (mode_r == CAM_MUX8_B) begin
			port_b_oe[PB_WRH_BIT] = 1'b0; // high strobe input
		end
	end

	cam_clk_div u_clk_div (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.div_sel  (clk_div_r[3:0]),
		.clk_out  (clk_out)
	);
	assign clk_out_slew = clk_div_r[CLK_SLEW_LO+1:CLK_SLEW_LO];
endmodule

// File: cam_map_chk.sv
// concurrent checks on the address map top ports
`timescale 1ns/1ps
module cam_map_chk import cam_pkg::*; (
	input wire logic          core_clk,
	input wire logic          rst_b,
	input wire cam_host_req_s host_req,
	input wire logic [7:0]    host_rdata,
	input wire logic          host_rvalid,
	input wire cam_mode_e     host_mode,
	input wire logic [NUM_OBJ:1] obj_is_tx,
	input wire cam_mask_s     eng_masks,
	input wire logic [7:0]    port_a_oe,
	input wire logic [1:0]    clk_out_slew
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// read wins over write, so a write counts only alone
	logic       rd;
	logic       wo;
	logic [7:0] ad;
	logic [7:0] wd;
	logic [3:0] ob;
	assign rd = host_req.rd;
	assign wo = host_req.wr & ~host_req.rd;
	assign ad = host_req.addr;
	assign wd = host_req.wdata;
	assign ob = host_req.addr[7:4];
	property p_ans; rd |=> host_rvalid; endproperty
	a_ans: assert property (p_ans) else $error("read not answered");
	property p_quiet; !rd |=> !host_rvalid; endproperty
	a_quiet: assert property (p_quiet) else $error("stray answer");
	property p_rsync; rd && ad == A_RESYNC |=> host_rdata == RESYNC_VAL;
	endproperty
	a_rsync: assert property (p_rsync) else $error("resync read");
	property p_rsvd; rd && ad == A_RSVD_03 |=> host_rdata == RSVD_VAL;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved read");
	property p_last; !obj_is_tx[15]; endproperty
	a_last: assert property (p_last) else $error("last object tx");
	property p_pa; host_mode inside {CAM_MUX16, CAM_SPLIT8} |->
		port_a_oe == 8'h00; endproperty
	a_pa: assert property (p_pa) else $error("port a driven");
	property p_slew; wo && ad == A_CLK_OUT |=>
		clk_out_slew == $past(wd[5:4]); endproperty
	a_slew: assert property (p_slew) else $error("slew wrong");
	property p_gm; wo && ad == A_GM_SHORT |=>
		eng_masks.short_id[7:0] == $past(wd); endproperty
	a_gm: assert property (p_gm) else $error("mask wrong");
	property p_dir; wo && ad[3:0] == IDX_FCFG && ob != 4'h0 && ob != LAST_OBJ
		|=> obj_is_tx[$past(ob)] == $past(wd[FCFG_DIR_BIT]); endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	c_rsync: cover property (rd && ad == A_RESYNC);
	c_dir: cover property (wo && ad == 8'h36);
	c_split: cover property (host_mode == CAM_SPLIT8);
endmodule

// File: cam_host_bfm.sv
// host microcontroller model issuing byte reads and writes
`timescale 1ns/1ps
module cam_host_bfm import cam_pkg::*; (
	input  wire logic       core_clk,
	input  wire logic       host_rvalid,
	input  wire logic [7:0] host_rdata,
	output cam_host_req_s   req
);
	// the host alone starts every transfer
	initial req = '0;
	// one write pulse, taken at the following edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) req <= '{1'b0, 1'b1, a, d};
		@(posedge core_clk) req <= '0;
	endtask
	// read pulse; answer is looked at mid-cycle, off the edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output bit ok);
		int n;
		ok = 0;
		d = 8'h00;
		@(posedge core_clk) req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge core_clk) req <= '0;
		for (n = 0; n < 4 && !ok; n++) begin
			@(negedge core_clk);
			if (host_rvalid === 1'b1) begin
				d = host_rdata;
				ok = 1;
			end
		end
	endtask
endmodule

// File: test_can_controller_address_map.sv
// self-checking bench for the controller address map
`timescale 1ns/1ps
module test_can_controller_address_map import cam_pkg::*;;
	logic          core_clk = 0, rst_b = 0, sl = 0, sh = 0;
	logic          txd = 0, rxd = 0;
	logic [3:0]    eo = 4'h0;
	logic [7:0]    pb_in = 8'h3C;
	cam_eng_req_s  er = '0;
	cam_host_req_s hreq;
	cam_mode_e     mode;
	logic [7:0]    hrd, erd, pa_out, pa_oe, pb_out, pb_oe;
	logic          hrv, intb, cko, ra, ta, tb;
	int            errors = 0, total_checks = 0;
	int            hi_n = 0;
	// addr, write value, expected read back; 04/05 hold past storage reads
	localparam logic [23:0] T[15] = '{24'h025A5A, 24'h061212, 24'h073434,
		24'h0B9C9C, 24'h0F7171, 24'h2F4848, 24'h3F3C3C, 24'h4F2D2D,
		24'h17A5A5, 24'h0466A5, 24'h057700, 24'h03AA00, 24'h6F5500,
		24'hFF11FF, 24'hEF0F0F};
	always #2.5 core_clk = ~core_clk;
	cam_host_bfm h (.core_clk(core_clk), .host_rvalid(hrv),
		.host_rdata(hrd), .req(hreq));
	cam_map_top dut (.core_clk(core_clk), .rst_b(rst_b),
		.host_select_low(sl), .host_select_high(sh),
		.host_serial_strap(1'b0), .host_req(hreq), .host_rdata(hrd),
		.host_rvalid(hrv), .host_mode(mode), .eng_req(er),
		.eng_rdata(erd), .eng_tx_done(txd), .eng_rx_done(rxd),
		.eng_evt_obj(eo), .eng_tx_bit(1'b0), .eng_rx_bit(ra),
		.obj_is_tx(), .eng_masks(), .eng_bus_cfg(), .eng_bit_time(),
		.bus_receive_a(1'b1), .bus_receive_b(1'b0),
		.bus_transmit_a(ta), .bus_transmit_b(tb), .port_a_in(8'h00),
		.port_a_out(pa_out), .port_a_oe(pa_oe), .port_b_in(pb_in),
		.port_b_out(pb_out), .port_b_oe(pb_oe), .int_b(intb), .clk_out(cko),
		.clk_out_slew());
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	// read one byte; a missing answer ends the run
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		bit         ok;
		h.rd(a, d, ok);
		if (!ok) begin
			errors++;
			$display("mismatch %0t no answer at %h", $time, a);
			complete_run();
		end
		ck(d, e);
	endtask
	// one engine event pulse naming an object
	task automatic ev(input logic t, input logic r, input logic [3:0] o);
		@(posedge core_clk) {txd, rxd, eo} <= {t, r, o};
		@(posedge core_clk) {txd, rxd} <= 2'b00;
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1;
		@(posedge core_clk);
		rc(A_MAIN_CTRL, CTRL_RST);
		rc(A_CLK_OUT, REG_RST);
		ck({7'h00, intb}, 8'h01);
		$display("reset test done");
		foreach (T[i]) begin
			h.wr(T[i][23:16], T[i][15:8]);
			rc(T[i][23:16], T[i][7:0]);
		end
		$display("table test done");
		// bus config 48: comparator bypassed, second line follows the first
		ck({5'h00, ra, ta, tb}, 8'h04);
		h.wr(A_PA_DIR, 8'hFF);
		h.wr(A_PA_OUT, 8'hA5);
		@(negedge core_clk);
		ck(pa_oe, 8'hFF);
		ck(pa_out, 8'hA5);
		rc(A_PB_LVL, 8'h3C);
		// host and engine hit storage in the same cycle
		fork
			rc(8'h17, 8'hA5);
			@(posedge core_clk) er <= '{1'b1, 4'h2, 4'h7, 8'h5A};
		join
		@(posedge core_clk) er <= '{1'b0, 4'h1, 4'h7, 8'h00};
		rc(8'h27, 8'h5A);
		@(negedge core_clk);
		ck(erd, 8'hA5);
		$display("storage test done");
		h.wr(8'h31, 8'h00);
		h.wr(8'h36, 8'h08);
		ev(1'b1, 1'b1, 4'h3);
		ev(1'b1, 1'b0, 4'hF);
		rc(8'h31, 8'h01);
		rc(A_INT_SRC, INT_BASE + 8'h03);
		h.wr(A_MAIN_CTRL, 8'h03);
		@(negedge core_clk);
		ck({7'h00, intb}, 8'h00);
		// interrupt routed to port b bit six: open drain, drives low only
		h.wr(A_HOST_CFG, 8'h20);
		@(negedge core_clk);
		ck({4'h0, pb_oe[7:6], pb_out[7:6]}, 8'h04);
		h.wr(8'h31, 8'h00);
		rc(A_INT_SRC, 8'h00);
		ck({7'h00, intb}, 8'h01);
		$display("event test done");
		h.wr(A_CLK_OUT, 8'h30);
		repeat (4) begin
			@(negedge core_clk);
			ck({7'h00, cko}, 8'h01);
		end
		// divide by three: any six cycles hold four high ones
		h.wr(A_CLK_OUT, 8'h32);
		@(posedge core_clk);
		repeat (6) begin
			@(negedge core_clk);
			hi_n += cko;
		end
		ck(8'(hi_n), 8'h04);
		$display("clock test done");
		// second reset with the split bus straps
		@(posedge core_clk) rst_b <= 0;
		sh <= 1;
		sl <= 1;
		repeat (10) @(posedge core_clk);
		rst_b <= 1;
		repeat (2) @(posedge core_clk);
		ck({5'h00, mode}, {5'h00, CAM_SPLIT8});
		h.wr(A_PA_DIR, 8'hFF);
		@(negedge core_clk);
		ck(pa_oe, 8'h00);
		$display("mode test done");
		complete_run();
	end
endmodule
bind cam_map_top cam_map_chk chk (.core_clk(core_clk), .rst_b(rst_b),
	.host_req(host_req), .host_rdata(host_rdata),
	.host_rvalid(host_rvalid), .host_mode(host_mode),
	.obj_is_tx(obj_is_tx), .eng_masks(eng_masks),
	.port_a_oe(port_a_oe), .clk_out_slew(clk_out_slew));
